// ---- design/timer16_compare_capture_irq_regs.sv ----
// compare, capture and interrupt registers of four 16-bit timers
//
// Overview of operation
// [RQ1] each compare value is compared against the count on every tick
// [RQ2] a match raises a compare flag and a compare output event
// [RQ3] compare writes go through the high-byte latch, both bytes at once
// [RQ4] one high-byte latch is shared by all 16-bit registers
// [RQ5] a capture event copies the count into the capture register
// [RQ6] timer 1 may take its capture event from the analog comparator
// [RQ7] capture register may serve as top; match ends the count sequence
// [RQ8] reading a capture low byte loads its high byte into the latch
// [RQ9] capture request needs mask bit 5, global enable and capture flag
// [RQ10] compare c request needs mask bit 3, global enable and its flag
// [RQ11] compare b request needs mask bit 2, global enable and its flag
// [RQ12] compare a request needs mask bit 1, global enable and its flag
// [RQ13] overflow request needs mask bit 0, global enable and its flag
// [RQ14] compare flag sets two cycles after a match; forced strobes never
// [RQ15] writing one clears a flag, writing zero leaves it
// [RQ16] executing an interrupt vector clears its flag automatically
// [RQ17] a count write suppresses compare matches on the next timer tick
// [RQ18] reserved bits 7, 6 and 4 read zero and ignore writes
`timescale 1ns/1ns
`default_nettype none
`include "timer16_cfg.svh"

module timer16_compare_capture_irq_regs #(
    parameter int ADDR_W     = 12,
    parameter int NUM_TIMERS = 4
) (
    input  wire logic                                   sys_clk,
    input  wire logic                                   rst,
    input  wire logic                                   hsel,
    input  wire logic [ADDR_W-1:0]                      haddr,
    input  wire logic [1:0]                             htrans,
    input  wire logic                                   hwrite,
    input  wire logic [2:0]                             hsize,
    input  wire logic [31:0]                            hwdata,
    input  wire logic                                   hready,
    output var  logic                                   hreadyout,
    output var  logic                                   hresp,
    output var  logic [31:0]                            hrdata,
    input  wire timer16_pkg::timer_in_t [NUM_TIMERS-1:0] timer_in,
    input  wire logic [NUM_TIMERS-1:0]                  capture_input_pin,
    input  wire logic                                   acomp_out,
    input  wire logic                                   global_irq_enable,
    input  wire logic [NUM_TIMERS-1:0][7:0]             vector_ack,
    output var  timer16_pkg::timer_out_t [NUM_TIMERS-1:0] timer_out,
    output var  logic [NUM_TIMERS-1:0][7:0]             irq_req,
    output var  logic                                   irq
);

    if (NUM_TIMERS != 4) begin : g_bad_timers
        $error("timer block serves exactly four timers");
    end
    if (ADDR_W < 12) begin : g_bad_addr
        $error("address must reach index 0x1e1");
    end

    localparam int T = NUM_TIMERS;
    // timer 5 flags live here but have no bus location in this block
    localparam logic [3:0] FLAG_MAPPED = 4'h7;
    localparam logic [9:0] FLAG_IDX [4] = '{`IDX_FLAGS_T1, `IDX_FLAGS_T3,
                                            `IDX_FLAGS_T4, 10'h000};
    localparam logic [9:0] MASK_IDX [4] = '{`IDX_MASK_T1, `IDX_MASK_T3,
                                            `IDX_MASK_T4, `IDX_MASK_T5};
    localparam logic [9:0] CAPL_IDX [4] = '{`IDX_CAP_LO_T1, `IDX_CAP_LO_T3,
                                            `IDX_CAP_LO_T4, `IDX_CAP_LO_T5};
    localparam logic [9:0] CAPH_IDX [4] = '{`IDX_CAP_HI_T1, `IDX_CAP_HI_T3,
                                            `IDX_CAP_HI_T4, `IDX_CAP_HI_T5};

    // bus pipeline state
    logic        rd_q,    rd_d;
    logic        wr_q,    wr_d;
    logic [9:0]  idx_q,   idx_d;
    logic        rdy_q,   rdy_d;
    logic [31:0] rdata_q, rdata_d;

    // register file
    logic [7:0]  temp_q,  temp_d;
    logic [7:0]  capctl_q, capctl_d;
    logic [7:0]  srcctl_q, srcctl_d;
    logic [15:0] cmpc_q,  cmpc_d;
    logic [7:0]  flag_q   [T];
    logic [7:0]  flag_d   [T];
    logic [7:0]  mask_q   [T];
    logic [7:0]  mask_d   [T];
    logic [15:0] cap_q    [T];
    logic [15:0] cap_d    [T];
    logic [T-1:0][7:0]                  req_d;
    logic                               irq_d;
    timer16_pkg::timer_out_t [T-1:0]    tout_d;

    // per-timer event logic
    logic [T-1:0]      block_q, block_d;
    logic [T-1:0][2:0] hit_q,   hit_d;
    logic [T-1:0]      cap_ev;
    logic [T-1:0]      top_hit;
    logic [2:0]        pin_sync_q [T];
    logic [2:0]        acomp_sync_q;

    // comparator output is asynchronous: two stages before use
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            acomp_sync_q <= 3'h0;
        end else begin
            acomp_sync_q <= {acomp_sync_q[1:0], acomp_out};
        end
    end

    for (genvar t = 0; t < T; t++) begin : g_timer
        logic [15:0] cmp_c;
        logic        src_lvl;
        logic        src_old;
        logic        edge_rise;
        logic        top_mode;

        always_ff @(posedge sys_clk) begin
            if (rst) begin
                pin_sync_q[t] <= 3'h0;
            end else begin
                pin_sync_q[t] <= {pin_sync_q[t][1:0], capture_input_pin[t]};
            end
        end

        // compare c of timer 5 is held in this block
        assign cmp_c = (t == 3) ? cmpc_q : timer_in[t].compare_c;
        assign top_mode  = capctl_q[`CAP_TOP_LSB + t];
        assign edge_rise = capctl_q[`CAP_EDGE_LSB + t];

        // only the second and third stages are looked at
        if (t == 0) begin : g_acomp
            assign src_lvl = srcctl_q[`SRC_ACOMP_BIT] ?
                             acomp_sync_q[1] : pin_sync_q[t][1]; // see [RQ6]
            assign src_old = srcctl_q[`SRC_ACOMP_BIT] ?
                             acomp_sync_q[2] : pin_sync_q[t][2];
        end else begin : g_pin
            assign src_lvl = pin_sync_q[t][1];
            assign src_old = pin_sync_q[t][2];
        end

        // capture input is unused while the capture value is the top
        assign cap_ev[t] = ~top_mode & (src_lvl != src_old) &
                           (src_lvl == edge_rise);             // see [RQ5]
        assign top_hit[t] = top_mode & timer_in[t].tick & ~block_q[t] &
                            (timer_in[t].count == cap_q[t]);    // see [RQ7]

        always_comb begin
            block_d[t] = block_q[t];
            if (timer_in[t].count_write) begin
                block_d[t] = 1'b1;                             // see [RQ17]
            end else if (timer_in[t].tick) begin
                block_d[t] = 1'b0;
            end
            hit_d[t] = 3'h0;
            if (timer_in[t].tick && !block_q[t]) begin         // see [RQ17]
                hit_d[t][0] = timer_in[t].count == timer_in[t].compare_a;
                hit_d[t][1] = timer_in[t].count == timer_in[t].compare_b;
                hit_d[t][2] = timer_in[t].count == cmp_c;     // see [RQ1]
            end
        end
    end

    always_comb begin
        logic        acc;
        logic [7:0]  set;
        logic [7:0]  clr;
        logic [7:0]  wb;
        acc      = hsel & hready & htrans[1];
        set      = 8'h00;
        clr      = 8'h00;
        wb       = hwdata[7:0];
        rd_d     = acc & ~hwrite;
        wr_d     = acc & hwrite;
        idx_d    = acc ? haddr[11:2] : idx_q;
        // reads take one wait state so a preceding write is visible
        rdy_d    = ~(acc & ~hwrite);
        rdata_d  = rdata_q;
        temp_d   = temp_q;
        capctl_d = capctl_q;
        srcctl_d = srcctl_q;
        cmpc_d   = cmpc_q;
        irq_d    = 1'b0;

        if (wr_q && idx_q == `IDX_CAP_CTRL) begin
            capctl_d = wb;
        end
        if (wr_q && idx_q == `IDX_SRC_CTRL) begin
            srcctl_d = {7'h00, wb[`SRC_ACOMP_BIT]};
        end
        if (wr_q && idx_q == `IDX_CMPC_HI_T5) begin
            temp_d = wb;                                       // see [RQ4]
        end
        if (wr_q && idx_q == `IDX_CMPC_LO_T5) begin
            cmpc_d = {temp_q, wb};                             // see [RQ3]
        end

        for (int t = 0; t < T; t++) begin
            set = 8'h00;
            set[`BIT_CAPTURE]   = cap_ev[t] | top_hit[t];
            // forced strobes never reach the registered hits
            set[`BIT_COMPARE_C] = hit_q[t][2];                 // see [RQ14]
            set[`BIT_COMPARE_B] = hit_q[t][1];
            set[`BIT_COMPARE_A] = hit_q[t][0];
            set[`BIT_OVERFLOW]  = timer_in[t].overflow;
            clr = vector_ack[t];                               // see [RQ16]
            if (wr_q && FLAG_MAPPED[t] && idx_q == FLAG_IDX[t]) begin
                clr = clr | wb;                                // see [RQ15]
            end
            // a new event wins over a clear in the same cycle
            flag_d[t] = ((flag_q[t] & ~clr) | set) & `IRQ_BITS_USED;

            mask_d[t] = mask_q[t];
            if (wr_q && idx_q == MASK_IDX[t]) begin
                mask_d[t] = wb & `IRQ_BITS_USED;               // see [RQ18]
            end

            cap_d[t] = cap_q[t];
            if (wr_q && idx_q == CAPH_IDX[t]) begin
                temp_d = wb;                                   // see [RQ4]
            end
            // hardware capture takes precedence over a software write
            if (cap_ev[t]) begin
                cap_d[t] = timer_in[t].count;                  // see [RQ5]
            end else if (wr_q && idx_q == CAPL_IDX[t]) begin
                cap_d[t] = {temp_q, wb};
            end

            // each bit needs its enable, its flag and global enable
            req_d[t] = global_irq_enable ?
                       (flag_q[t] & mask_q[t]) : 8'h00;        // see [RQ9]
            // bits 3..0 follow the same form                    see [RQ10]
            // compare b and a share the masking above           see [RQ11]
            // one and zero too                        see [RQ12] see [RQ13]
            irq_d = irq_d | (|req_d[t]);

            tout_d[t].compare_event = hit_d[t] |
                                      timer_in[t].force_strobe; // see [RQ2]
            tout_d[t].top_reached   = top_hit[t];
        end

        if (rd_q) begin
            rdy_d   = 1'b1;
            rdata_d = 32'h0000_0000;
            case (idx_q)
                `IDX_CAP_CTRL:   rdata_d[7:0] = capctl_q;
                `IDX_SRC_CTRL:   rdata_d[7:0] = srcctl_q;
                `IDX_CMPC_LO_T5: rdata_d[7:0] = cmpc_q[7:0];
                `IDX_CMPC_HI_T5: rdata_d[7:0] = cmpc_q[15:8];
                default:         rdata_d[7:0] = 8'h00;
            endcase
            for (int t = 0; t < T; t++) begin
                if (FLAG_MAPPED[t] && idx_q == FLAG_IDX[t]) begin
                    rdata_d[7:0] = flag_q[t];                  // see [RQ18]
                end
                if (idx_q == MASK_IDX[t]) begin
                    rdata_d[7:0] = mask_q[t];
                end
                if (idx_q == CAPL_IDX[t]) begin
                    rdata_d[7:0] = cap_q[t][7:0];
                    temp_d       = cap_q[t][15:8];             // see [RQ8]
                end
                if (idx_q == CAPH_IDX[t]) begin
                    rdata_d[7:0] = temp_q;                     // see [RQ8]
                end
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_q      <= 1'b0;
            wr_q      <= 1'b0;
            idx_q     <= 10'h000;
            rdy_q     <= 1'b1;
            rdata_q   <= 32'h0000_0000;
            temp_q    <= `RST_BYTE;
            capctl_q  <= `RST_CAP_CTRL;
            srcctl_q  <= `RST_BYTE;
            cmpc_q    <= `RST_WORD;
            block_q   <= '0;
            hit_q     <= '0;
            irq_req   <= '0;
            irq       <= 1'b0;
            timer_out <= '0;
            for (int t = 0; t < T; t++) begin
                flag_q[t] <= `RST_BYTE;
                mask_q[t] <= `RST_BYTE;
                cap_q[t]  <= `RST_WORD;
            end
        end else begin
            rd_q      <= rd_d;
            wr_q      <= wr_d;
            idx_q     <= idx_d;
            rdy_q     <= rdy_d;
            rdata_q   <= rdata_d;
            temp_q    <= temp_d;
            capctl_q  <= capctl_d;
            srcctl_q  <= srcctl_d;
            cmpc_q    <= cmpc_d;
            block_q   <= block_d;
            hit_q     <= hit_d;
            irq_req   <= req_d;
            irq       <= irq_d;
            timer_out <= tout_d;
            for (int t = 0; t < T; t++) begin
                flag_q[t] <= flag_d[t];
                mask_q[t] <= mask_d[t];
                cap_q[t]  <= cap_d[t];
            end
        end
    end

    // responses are always okay; unmapped reads return zero
    always_ff @(posedge sys_clk) begin
        hresp <= 1'b0;
    end

    assign hreadyout = rdy_q;
    assign hrdata    = rdata_q;

endmodule

`default_nettype wire

// ---- design/timer16_cfg.svh ----
// register indices, field positions and reset values of the timer block
`ifndef TIMER16_CFG_SVH
`define TIMER16_CFG_SVH

// register indices; byte address on the bus is four times the index
`define IDX_FLAGS_T1      10'h036
`define IDX_FLAGS_T3      10'h038
`define IDX_FLAGS_T4      10'h039
`define IDX_MASK_T1       10'h06f
`define IDX_MASK_T3       10'h071
`define IDX_MASK_T4       10'h072
`define IDX_MASK_T5       10'h073
`define IDX_CAP_LO_T1     10'h086
`define IDX_CAP_HI_T1     10'h087
`define IDX_CAP_LO_T3     10'h096
`define IDX_CAP_HI_T3     10'h097
`define IDX_CAP_LO_T4     10'h0a6
`define IDX_CAP_HI_T4     10'h0a7
`define IDX_CAP_LO_T5     10'h126
`define IDX_CAP_HI_T5     10'h127
`define IDX_CMPC_LO_T5    10'h12c
`define IDX_CMPC_HI_T5    10'h12d
`define IDX_CAP_CTRL      10'h1e0
`define IDX_SRC_CTRL      10'h1e1

// bit positions shared by mask and flag registers
`define BIT_CAPTURE       5
`define BIT_COMPARE_C     3
`define BIT_COMPARE_B     2
`define BIT_COMPARE_A     1
`define BIT_OVERFLOW      0
`define IRQ_BITS_USED     8'h2f

// capture control: [3:0] rising edge select, [7:4] capture value is top
`define CAP_EDGE_LSB      0
`define CAP_TOP_LSB       4
`define SRC_ACOMP_BIT     0

`define RST_BYTE          8'h00
`define RST_WORD          16'h0000
`define RST_CAP_CTRL      8'h0f

`endif

// ---- design/timer16_pkg.sv ----
// types shared by the timer compare, capture and interrupt block
package timer16_pkg;

    // per-timer signals from the counter core, all on sys_clk
    typedef struct packed {
        logic [15:0] count;        // timer_count_value
        logic [15:0] compare_a;
        logic [15:0] compare_b;
        logic [15:0] compare_c;    // unused for timer 5, held here
        logic        tick;         // one-cycle timer clock enable
        logic        count_write;  // cpu wrote the count register
        logic        overflow;     // one-cycle overflow event
        logic [2:0]  force_strobe; // forced_compare_strobe c,b,a
    } timer_in_t;

    // per-timer results towards counter core and waveform logic
    typedef struct packed {
        logic [2:0] compare_event; // drives compare_output_pin c,b,a
        logic       top_reached;   // capture value used as top hit
    } timer_out_t;

endpackage

// ---- verification/timer16_irq_properties.sv ----
// port checker for the timer compare, capture and interrupt block
`timescale 1ns/1ns
`default_nettype none
module timer16_irq_properties #(
    parameter int NUM_TIMERS = 4
) (
    input wire logic                                    sys_clk,
    input wire logic                                    rst,
    input wire logic                                    hsel,
    input wire logic [1:0]                              htrans,
    input wire logic                                    hwrite,
    input wire logic                                    hready,
    input wire logic                                    hreadyout,
    input wire timer16_pkg::timer_in_t [NUM_TIMERS-1:0]  timer_in,
    input wire logic                                    global_irq_enable,
    input wire timer16_pkg::timer_out_t [NUM_TIMERS-1:0] timer_out,
    input wire logic [NUM_TIMERS-1:0][7:0]              irq_req,
    input wire logic                                    irq
);
    timer16_pkg::timer_in_t t0;
    logic                   blk_q;
    logic                   blk_d;
    assign t0 = timer_in[0];
    // a count write blocks the next tick, even one far off
    always_comb begin
        blk_d = blk_q;
        if (t0.count_write) begin
            blk_d = 1'b1;
        end else if (t0.tick) begin
            blk_d = 1'b0;
        end
    end
    always_ff @(posedge sys_clk) begin
        blk_q <= rst ? 1'b0 : blk_d;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    req_gie_a: assert property (
        irq_req != '0 |-> $past(global_irq_enable))
        else $error("irq request without global enable");
    irq_off_a: assert property (!global_irq_enable |=> !irq)
        else $error("irq high with global enable off");
    reserved_quiet_a: assert property (
        ((irq_req[0] | irq_req[1] | irq_req[2] | irq_req[3]) & 8'hd0) == 8'h00)
        else $error("request on a reserved bit");
    read_wait_a: assert property (
        hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    write_ready_a: assert property (
        hsel && hready && htrans[1] && hwrite |=> hreadyout)
        else $error("write not zero wait");
    match_event_a: assert property (
        t0.tick && !t0.count_write && !blk_q && t0.count == t0.compare_a
        |=> timer_out[0].compare_event[0])
        else $error("compare match missed");
    match_block_a: assert property (
        t0.tick && blk_q && !t0.force_strobe[0]
        |=> !timer_out[0].compare_event[0])
        else $error("match after count write not blocked");
    event_cause_a: assert property (
        timer_out[0].compare_event[0]
        |-> $past(t0.tick) || $past(t0.force_strobe[0]))
        else $error("compare event without cause");
    cover property (irq_req[3][3]);
    cover property (timer_out[2].top_reached);
    cover property ($rose(irq));
endmodule

bind timer16_compare_capture_irq_regs timer16_irq_properties #(
    .NUM_TIMERS(NUM_TIMERS)
) u_timer16_irq_properties (.sys_clk, .rst, .hsel, .htrans, .hwrite,
    .hready, .hreadyout, .timer_in, .global_irq_enable, .timer_out,
    .irq_req, .irq);
`default_nettype wire

// ---- verification/timer_core_model.sv ----
// counter core model feeding all four timers of the block
`timescale 1ns/1ns
`default_nettype none
module timer_core_model (
    input  wire logic                         sys_clk,
    input  wire logic                         rst,
    input  wire logic                         run,
    input  wire logic                         cw,
    input  wire logic                         ovf,
    input  wire logic [2:0]                   frc,
    input  wire logic [15:0]                  cmp,
    output var  timer16_pkg::timer_in_t [3:0] tin
);
    logic [15:0] count_q;
    logic [15:0] count_d;
    always_comb begin
        count_d = count_q;
        if (cw) begin
            count_d = cmp;
        end else if (run) begin
            count_d = count_q + 16'h0001;
        end
    end
    always_ff @(posedge sys_clk) begin
        count_q <= rst ? 16'h0000 : count_d;
    end
    // one shared count keeps expectations simple; a, b, c all use cmp
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            tin[i] = {count_q, cmp, cmp, cmp, run, cw, ovf, frc};
        end
    end
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the timer compare, capture and irq block
`timescale 1ns/1ns
`default_nettype none
`include "timer16_cfg.svh"
module tb;
    logic        sys_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'b00;
    logic [31:0] hwdata = 32'h0, hrdata;
    logic        hreadyout, hresp, irq;
    logic        acomp = 1'b0, gie = 1'b0, run = 1'b0, cw = 1'b0, ovf = 1'b0;
    logic [3:0]  cap_pin = 4'h0;
    logic [2:0]  frc = 3'h0;
    logic [15:0] cmp = 16'h0040;
    logic [3:0][7:0] ack = 32'h0, irq_req;
    timer16_pkg::timer_in_t [3:0] tin;
    timer16_pkg::timer_out_t [3:0] tout;
    int          fails = 0, samples_checked = 0;

    always #50 sys_clk = ~sys_clk;

    timer_core_model u_timer_core_model (.sys_clk, .rst, .run, .cw, .ovf,
        .frc, .cmp, .tin);
    timer16_compare_capture_irq_regs u_timer16_compare_capture_irq_regs (
        .sys_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010),
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
        .timer_in(tin), .capture_input_pin(cap_pin), .acomp_out(acomp),
        .global_irq_enable(gie), .vector_ack(ack), .timer_out(tout),
        .irq_req, .irq);

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // address phase held until ready, then data phase until ready again
    task automatic bus(input logic [9:0] i, input logic w,
                       input logic [7:0] d, output logic [7:0] q);
        hsel <= 1'b1;
        haddr <= {i, 2'b00};
        htrans <= 2'b10;
        hwrite <= w;
        cyc(1);
        while (hreadyout !== 1'b1) cyc(1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        cyc(1);
        while (hreadyout !== 1'b1) cyc(1);
        q = hrdata[7:0];
        chk({7'h00, hresp}, 8'h00);
    endtask
    task automatic wr(input logic [9:0] i, input logic [7:0] d);
        logic [7:0] q;
        bus(i, 1'b1, d, q);
    endtask
    task automatic rd(input logic [9:0] i, input logic [7:0] e);
        logic [7:0] q;
        bus(i, 1'b0, 8'h00, q);
        chk(q, e);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        cyc(5000);
        fails++;
        results();
    end

    initial begin
        cyc(20);
        rst <= 1'b0;
        cyc(1);
        rd(`IDX_FLAGS_T1, `RST_BYTE);
        rd(`IDX_CAP_CTRL, `RST_CAP_CTRL);
        rd(10'h200, 8'h00);
        wr(`IDX_MASK_T1, 8'hff);
        rd(`IDX_MASK_T1, `IRQ_BITS_USED);
        wr(`IDX_CMPC_HI_T5, 8'ha5);
        wr(`IDX_CMPC_LO_T5, 8'h3c);
        wr(`IDX_CMPC_HI_T5, 8'h12);
        rd(`IDX_CMPC_HI_T5, 8'ha5);
        rd(`IDX_CMPC_LO_T5, 8'h3c);
        wr(`IDX_CAP_LO_T4, 8'h77);
        rd(`IDX_CAP_HI_T4, 8'h12);
        gie <= 1'b1;
        run <= 1'b1;
        cyc(80);
        run <= 1'b0;
        cyc(3);
        chk(irq_req[0], 8'h0e);
        chk(irq_req[1], 8'h00);
        chk(irq, 1'b1);
        rd(`IDX_FLAGS_T3, 8'h0e);
        gie <= 1'b0;
        cyc(2);
        chk(irq, 1'b0);
        gie <= 1'b1;
        wr(`IDX_FLAGS_T1, 8'h00);
        rd(`IDX_FLAGS_T1, 8'h0e);
        wr(`IDX_FLAGS_T1, 8'h02);
        rd(`IDX_FLAGS_T1, 8'h0c);
        ack[0] <= 8'h08;
        cyc(1);
        ack[0] <= 8'h00;
        rd(`IDX_FLAGS_T1, 8'h04);
        wr(`IDX_FLAGS_T1, 8'hff);
        frc <= 3'b111;
        cyc(1);
        frc <= 3'b000;
        ovf <= 1'b1;
        cyc(1);
        chk({5'h00, tout[0].compare_event}, 8'h07);
        ovf <= 1'b0;
        cyc(3);
        chk(irq_req[0], 8'h01);
        rd(`IDX_FLAGS_T1, 8'h01);
        // frozen count makes the captured value known
        cmp <= 16'h1234;
        cw <= 1'b1;
        cyc(1);
        cw <= 1'b0;
        cap_pin[1] <= 1'b1;
        cyc(5);
        wr(`IDX_CMPC_HI_T5, 8'h55);
        // overflow pulse above reached every timer, so bit 0 stays set
        rd(`IDX_FLAGS_T3, 8'h2f);
        rd(`IDX_CAP_LO_T3, 8'h34);
        rd(`IDX_CAP_HI_T3, 8'h12);
        wr(`IDX_SRC_CTRL, 8'h01);
        acomp <= 1'b1;
        cyc(5);
        rd(`IDX_CAP_LO_T1, 8'h34);
        chk(irq_req[0], 8'h21);
        wr(`IDX_FLAGS_T1, 8'hff);
        wr(`IDX_FLAGS_T4, 8'hff);
        wr(`IDX_CMPC_HI_T5, 8'h12);
        wr(`IDX_CMPC_LO_T5, 8'h72);
        wr(`IDX_MASK_T5, 8'h08);
        wr(`IDX_CAP_CTRL, 8'h4f);
        // loaded count equals every compare value but timer 5 compare c: that tick must be lost
        cmp <= 16'h1270;
        cw <= 1'b1;
        run <= 1'b1;
        cyc(1);
        cw <= 1'b0;
        cyc(10);
        run <= 1'b0;
        cyc(3);
        rd(`IDX_FLAGS_T1, 8'h00);
        rd(`IDX_FLAGS_T4, 8'h20);
        chk(irq_req[3], 8'h08);
        results();
    end
endmodule
`default_nettype wire
